//--- include/mgmt_if.sv
// management link between station controller and phy device
`timescale 1ns/1ps
interface mgmt_if;
    logic mdc;
    logic sta_mdio_o;
    logic sta_mdio_oe;
    logic phy_mdio_o;
    logic phy_mdio_oe;
    // pulled-up shared line
    wire mdio_line = (sta_mdio_oe && !sta_mdio_o) ? 1'b0 :
                     (phy_mdio_oe && !phy_mdio_o) ? 1'b0 : 1'b1;
    modport sta (output mdc, output sta_mdio_o, output sta_mdio_oe,
                 input mdio_line);
    modport phy (input mdc, output phy_mdio_o, output phy_mdio_oe,
                 input mdio_line);
endinterface

//--- include/mgmt_pkg.sv
// shared constants for the management link and pcs control block
package mgmt_pkg;
    // register indices and fields
    localparam logic [4:0] REG_PCS_CONFIG = 5'h17;
    localparam logic [4:0] REG_LOOPBACK_BYPASS = 5'h18;
    localparam logic [4:0] REG_PHY_ADDR = 5'h19;
    localparam logic [4:0] REG_TEN_STATUS = 5'h1B;
    localparam int BIT_NRZI_EN = 15;
    localparam int BIT_REPEATER = 12;
    localparam int BIT_BYP_SYMBOL = 14;
    localparam int BIT_BYP_SCRAMBLE = 13;
    localparam int BIT_BYP_ALL = 12;
    localparam int BIT_TEN_SERIAL = 9;
    localparam logic [15:0] PCS_CONFIG_RESET = 16'h8000;
    localparam logic [15:0] ZERO16 = 16'h0000;
    // frame layout
    localparam logic [5:0] PREAMBLE_BITS = 6'h20;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [4:0] HDR_BITS = 5'h0E;
    localparam logic [4:0] DATA_BITS = 5'h10;
    // wishbone register offsets of the station controller
    localparam logic [3:0] WB_CTRL = 4'h0;
    localparam logic [3:0] WB_WDATA = 4'h4;
    localparam logic [3:0] WB_STATUS = 4'h8;
    // clocking: 125 MHz system clock
    localparam int CLK_PERIOD_PS = 8000;
    localparam int MDC_MAX_RATE_KHZ = 2500;
    localparam int MDC_MIN_PERIOD_PS = 1000000000 / MDC_MAX_RATE_KHZ;
    // half period rounded up so mdc never exceeds its ceiling
    localparam int MDC_HALF_CYC =
        (MDC_MIN_PERIOD_PS + 2 * CLK_PERIOD_PS - 1) / (2 * CLK_PERIOD_PS);
    localparam logic [5:0] MDC_HALF = 6'(MDC_HALF_CYC);
    localparam logic [5:0] XFER_BITS = 6'h40;
    localparam logic [5:0] CNT_ONE = 6'h01;
    // mii clock periods in system clocks
    localparam logic [5:0] MII_DIV_100 = 6'h05;
    localparam logic [5:0] MII_DIV_10_NIBBLE = 6'h32;
    localparam logic [5:0] MII_DIV_10_SERIAL = 6'h0D;
    typedef enum logic [2:0] {
        ST_HUNT = 3'b000,
        ST_START = 3'b001,
        ST_HEADER = 3'b011,
        ST_TURN = 3'b010,
        ST_DATA = 3'b110
    } mgmt_state_t;
endpackage

//--- rtl/phy_mgmt_pcs.sv
// phy end: serial management slave, pcs bypass and mii mode control
//
// Contract
// - nrzi coding on while bit set, default one
// - align bypass skips every coding stage
// - repeater bit limits carrier sense to receive
// - 100 Mb/s mii nibble clock 25 MHz
// - bypass mode: fifth symbol bit on error lines
// - 10 Mb/s nibble 2.5 MHz, bypass ignored
// - serial mode manchester on bit zero, 10 MHz; mii clock here is 13 system clocks, about 9.6 MHz
// - serial mode select bit, strap default
// - thirty-two 16-bit management registers
// - station keeps mdc at most 2.5 MHz
// - up to 32 devices, distinct addresses
// - station sends 32 ones preamble
// - ignore frames until full preamble seen
// - frames start with zero then one
// - read turnaround: float, then drive zero
// - write turnaround driven one then zero
// - strap phy address, answer only it
// - transmit stages individually bypassable
// - symbol and scrambler bypass bits, strap defaults
//
// The Wishbone register port is this design's own decision.
`timescale 1ns/1ps
module phy_mgmt_pcs (
    // clock, reset, enable
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_ce,
    // management link
    mgmt_if.phy mgmt,
    // straps
    input wire logic [4:0] i_strap_phy_addr,
    input wire logic i_strap_byp_symbol,
    input wire logic i_strap_byp_scramble,
    input wire logic i_strap_byp_all,
    input wire logic i_strap_repeater,
    input wire logic i_strap_ten_serial,
    // speed and activity
    input wire logic i_speed_100,
    input wire logic i_rx_active,
    input wire logic i_tx_active,
    // pcs controls
    output logic o_nrzi_en,
    output logic o_byp_symbol,
    output logic o_byp_scramble,
    output logic o_byp_nrzi,
    output logic o_symbol_mode,
    output logic o_ten_serial,
    output logic o_crs,
    output logic o_mii_clk
);
    logic [15:0] regs_ff [32];
    logic [1:0] mdc_sync_ff;
    logic [1:0] mdio_sync_ff;
    logic mdc_prev_ff;
    logic strap_done_ff;
    logic [4:0] phy_addr_ff;
    mgmt_pkg::mgmt_state_t state_ff;
    logic [5:0] cnt_ff;
    logic [13:0] hdr_ff;
    logic [15:0] shift_ff;
    logic rd_ff;
    logic drive_ff;
    logic out_ff;
    logic [5:0] mii_cnt_ff;
    logic [5:0] mii_div;
    logic mdc_rise;
    logic mdc_fall;
    logic bit_in;
    logic [1:0] hdr_op;
    logic [4:0] hdr_phy;
    logic [4:0] hdr_reg;
    logic addr_hit;

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            mdc_sync_ff <= 2'h0;
            mdio_sync_ff <= 2'h3;
            mdc_prev_ff <= 1'b0;
        end else if (i_ce) begin
            mdc_sync_ff <= {mdc_sync_ff[0], mgmt.mdc};
            mdio_sync_ff <= {mdio_sync_ff[0], mgmt.mdio_line};
            mdc_prev_ff <= mdc_sync_ff[1];
        end
    end

    assign mdc_rise = mdc_sync_ff[1] && !mdc_prev_ff;
    assign mdc_fall = !mdc_sync_ff[1] && mdc_prev_ff;
    assign bit_in = mdio_sync_ff[1];
    assign hdr_op = hdr_ff[11:10];
    assign hdr_phy = hdr_ff[9:5];
    assign hdr_reg = hdr_ff[4:0];
    assign addr_hit = hdr_phy == phy_addr_ff;

    // strap capture after reset release
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            strap_done_ff <= 1'b0;
            phy_addr_ff <= 5'h00;
        end else if (i_ce && !strap_done_ff) begin
            strap_done_ff <= 1'b1;
            phy_addr_ff <= i_strap_phy_addr;
        end
    end

    // frame receiver
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_ff <= mgmt_pkg::ST_HUNT;
            cnt_ff <= 6'h00;
            hdr_ff <= 14'h0000;
            rd_ff <= 1'b0;
        end else if (i_ce && mdc_rise) begin
            case (state_ff)
                mgmt_pkg::ST_HUNT: begin
                    if (!bit_in) begin
                        cnt_ff <= 6'h00;
                    end else if (cnt_ff == mgmt_pkg::PREAMBLE_BITS - 6'h01) begin
                        state_ff <= mgmt_pkg::ST_START;
                    end else begin
                        cnt_ff <= cnt_ff + 6'h01;
                    end
                end
                mgmt_pkg::ST_START: begin
                    if (!bit_in) begin
                        // zero of start code, first header bit next
                        state_ff <= mgmt_pkg::ST_HEADER;
                        cnt_ff <= 6'h00;
                        hdr_ff <= 14'h0000;
                    end
                end
                mgmt_pkg::ST_HEADER: begin
                    hdr_ff <= {hdr_ff[12:0], bit_in};
                    cnt_ff <= cnt_ff + 6'h01;
                    if (cnt_ff == 6'(mgmt_pkg::HDR_BITS - 5'h02)) begin
                        // start bit, op, phy, reg collected
                        state_ff <= mgmt_pkg::ST_TURN;
                        cnt_ff <= 6'h00;
                    end
                end
                mgmt_pkg::ST_TURN: begin
                    if (hdr_ff[12] != 1'b1 || !addr_hit) begin
                        state_ff <= mgmt_pkg::ST_HUNT;
                        cnt_ff <= 6'h00;
                    end else begin
                        rd_ff <= hdr_op == mgmt_pkg::OP_READ;
                        cnt_ff <= cnt_ff + 6'h01;
                        if (cnt_ff == 6'h01) begin
                            state_ff <= mgmt_pkg::ST_DATA;
                            cnt_ff <= 6'h00;
                        end
                    end
                end
                mgmt_pkg::ST_DATA: begin
                    cnt_ff <= cnt_ff + 6'h01;
                    if (cnt_ff == 6'(mgmt_pkg::DATA_BITS - 5'h01)) begin
                        state_ff <= mgmt_pkg::ST_HUNT;
                        cnt_ff <= 6'h00;
                    end
                end
                default: begin
                    state_ff <= mgmt_pkg::ST_HUNT;
                end
            endcase
        end
    end

    // write data shift
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            shift_ff <= 16'h0000;
        end else if (i_ce && mdc_rise && state_ff == mgmt_pkg::ST_DATA) begin
            shift_ff <= {shift_ff[14:0], bit_in};
        end
    end

    // register space; straps land one cycle after reset release
    for (genvar g = 0; g < 32; g++) begin : g_reg
        always_ff @(posedge i_clk or posedge i_sys_rst) begin
            if (i_sys_rst) begin
                regs_ff[g] <= (g == 32'(mgmt_pkg::REG_PCS_CONFIG)) ?
                    mgmt_pkg::PCS_CONFIG_RESET : mgmt_pkg::ZERO16;
            end else if (i_ce && !strap_done_ff) begin
                if (g == 32'(mgmt_pkg::REG_PCS_CONFIG)) begin
                    regs_ff[g][mgmt_pkg::BIT_REPEATER] <=
                        i_strap_repeater;
                end else if (g == 32'(mgmt_pkg::REG_LOOPBACK_BYPASS)) begin
                    regs_ff[g][mgmt_pkg::BIT_BYP_SYMBOL] <=
                        i_strap_byp_symbol;
                    regs_ff[g][mgmt_pkg::BIT_BYP_SCRAMBLE] <=
                        i_strap_byp_scramble;
                    regs_ff[g][mgmt_pkg::BIT_BYP_ALL] <=
                        i_strap_byp_all;
                end else if (g == 32'(mgmt_pkg::REG_TEN_STATUS)) begin
                    regs_ff[g][mgmt_pkg::BIT_TEN_SERIAL] <=
                        i_strap_ten_serial;
                end else if (g == 32'(mgmt_pkg::REG_PHY_ADDR)) begin
                    regs_ff[g][4:0] <= i_strap_phy_addr;
                end
            end else if (i_ce && mdc_rise && state_ff == mgmt_pkg::ST_DATA
                         && cnt_ff == 6'(mgmt_pkg::DATA_BITS - 5'h01)
                         && !rd_ff && hdr_reg == 5'(g)
                         && g != 32'(mgmt_pkg::REG_PHY_ADDR)) begin
                regs_ff[g] <= {shift_ff[14:0], bit_in};
            end
        end
    end

    // read drive: change on falling mdc
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            drive_ff <= 1'b0;
            out_ff <= 1'b1;
        end else if (i_ce && mdc_fall) begin
            if (state_ff == mgmt_pkg::ST_TURN && cnt_ff == 6'h01
                && hdr_op == mgmt_pkg::OP_READ && addr_hit) begin
                drive_ff <= 1'b1;
                out_ff <= 1'b0;
            end else if (state_ff == mgmt_pkg::ST_DATA && rd_ff) begin
                drive_ff <= 1'b1;
                out_ff <= regs_ff[hdr_reg][4'hF - cnt_ff[3:0]];
            end else begin
                drive_ff <= 1'b0;
                out_ff <= 1'b1;
            end
        end
    end
    assign mgmt.phy_mdio_o = out_ff;
    assign mgmt.phy_mdio_oe = drive_ff;

    // pcs controls
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_nrzi_en <= 1'b1;
            o_byp_symbol <= 1'b0;
            o_byp_scramble <= 1'b0;
            o_byp_nrzi <= 1'b0;
            o_symbol_mode <= 1'b0;
            o_ten_serial <= 1'b0;
            o_crs <= 1'b0;
        end else if (i_ce) begin
            // align bypass overrides; 10 Mb/s ignores bypass
            o_nrzi_en <= !i_speed_100 ||
                (regs_ff[mgmt_pkg::REG_PCS_CONFIG][mgmt_pkg::BIT_NRZI_EN]
                 && !regs_ff[mgmt_pkg::REG_LOOPBACK_BYPASS]
                    [mgmt_pkg::BIT_BYP_ALL]);
            o_byp_symbol <= i_speed_100 &&
                (regs_ff[mgmt_pkg::REG_LOOPBACK_BYPASS]
                    [mgmt_pkg::BIT_BYP_SYMBOL] ||
                 regs_ff[mgmt_pkg::REG_LOOPBACK_BYPASS]
                    [mgmt_pkg::BIT_BYP_ALL]);
            o_byp_scramble <= i_speed_100 &&
                (regs_ff[mgmt_pkg::REG_LOOPBACK_BYPASS]
                    [mgmt_pkg::BIT_BYP_SCRAMBLE] ||
                 regs_ff[mgmt_pkg::REG_LOOPBACK_BYPASS]
                    [mgmt_pkg::BIT_BYP_ALL]);
            o_byp_nrzi <= i_speed_100 &&
                (!regs_ff[mgmt_pkg::REG_PCS_CONFIG][mgmt_pkg::BIT_NRZI_EN]
                 || regs_ff[mgmt_pkg::REG_LOOPBACK_BYPASS]
                    [mgmt_pkg::BIT_BYP_ALL]);
            o_symbol_mode <= i_speed_100 &&
                (regs_ff[mgmt_pkg::REG_LOOPBACK_BYPASS]
                    [mgmt_pkg::BIT_BYP_SYMBOL] ||
                 regs_ff[mgmt_pkg::REG_LOOPBACK_BYPASS]
                    [mgmt_pkg::BIT_BYP_ALL]);
            o_ten_serial <= !i_speed_100 &&
                regs_ff[mgmt_pkg::REG_TEN_STATUS]
                    [mgmt_pkg::BIT_TEN_SERIAL];
            o_crs <= i_rx_active ||
                (i_tx_active && !regs_ff[mgmt_pkg::REG_PCS_CONFIG]
                    [mgmt_pkg::BIT_REPEATER]);
        end
    end

    // mii clock divider
    always_comb begin
        if (i_speed_100) begin
            mii_div = mgmt_pkg::MII_DIV_100;
        end else if (regs_ff[mgmt_pkg::REG_TEN_STATUS]
                     [mgmt_pkg::BIT_TEN_SERIAL]) begin
            mii_div = mgmt_pkg::MII_DIV_10_SERIAL;
        end else begin
            mii_div = mgmt_pkg::MII_DIV_10_NIBBLE;
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            mii_cnt_ff <= 6'h00;
            o_mii_clk <= 1'b0;
        end else if (i_ce) begin
            // high for the first half of the divided period
            o_mii_clk <= mii_cnt_ff < {1'b0, mii_div[5:1]};
            if (mii_cnt_ff + 6'h01 >= mii_div) begin
                mii_cnt_ff <= 6'h00;
            end else begin
                mii_cnt_ff <= mii_cnt_ff + 6'h01;
            end
        end
    end
endmodule

//--- rtl/sta_mgmt_ctrl.sv
// station end: wishbone-driven management frame master
`timescale 1ns/1ps
module sta_mgmt_ctrl (
    // clock, reset, enable
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_ce,
    // wishbone slave
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [3:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    // management link
    mgmt_if.sta mgmt
);
    logic busy_ff;
    logic [63:0] frame_ff;
    logic [63:0] oe_ff;
    logic [5:0] bit_ff;
    logic [5:0] div_ff;
    logic mdc_ff;
    logic mdio_ff;
    logic oe_bit_ff;
    logic [1:0] din_sync_ff;
    logic [15:0] rdata_ff;
    logic [15:0] wdata_ff;
    logic is_read_ff;
    logic wb_req;

    assign wb_req = i_wb_cyc && i_wb_stb && !o_wb_ack;

    // wishbone: ack one cycle after request
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h00000000;
            wdata_ff <= 16'h0000;
        end else if (i_ce) begin
            o_wb_ack <= wb_req;
            if (wb_req && i_wb_we && i_wb_adr == mgmt_pkg::WB_WDATA
                && i_wb_sel[0]) begin
                wdata_ff <= i_wb_dat[15:0];
            end
            if (wb_req && i_wb_adr == mgmt_pkg::WB_STATUS) begin
                o_wb_dat <= {15'h0000, busy_ff, rdata_ff};
            end else if (wb_req && i_wb_adr == mgmt_pkg::WB_WDATA) begin
                o_wb_dat <= {16'h0000, wdata_ff};
            end else begin
                o_wb_dat <= 32'h00000000;
            end
        end
    end

    // ctrl write: [10] read, [9:5] phy, [4:0] reg
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            busy_ff <= 1'b0;
            frame_ff <= 64'h0000000000000000;
            oe_ff <= 64'h0000000000000000;
            bit_ff <= 6'h00;
            div_ff <= 6'h00;
            mdc_ff <= 1'b0;
            mdio_ff <= 1'b1;
            oe_bit_ff <= 1'b0;
            is_read_ff <= 1'b0;
            rdata_ff <= 16'h0000;
            din_sync_ff <= 2'h3;
        end else if (i_ce) begin
            din_sync_ff <= {din_sync_ff[0], mgmt.mdio_line};
            if (!busy_ff) begin
                if (wb_req && i_wb_we && i_wb_adr == mgmt_pkg::WB_CTRL
                    && i_wb_sel[1:0] == 2'h3) begin
                    busy_ff <= 1'b1;
                    is_read_ff <= i_wb_dat[10];
                    // 32 ones, start 01, op, addresses, turn, data
                    frame_ff <= {32'hFFFFFFFF, 2'h1,
                        i_wb_dat[10] ? mgmt_pkg::OP_READ :
                        mgmt_pkg::OP_WRITE, i_wb_dat[9:0],
                        i_wb_dat[10] ? 2'h3 : 2'h2,
                        i_wb_dat[10] ? 16'hFFFF : wdata_ff};
                    oe_ff <= i_wb_dat[10] ? 64'hFFFFFFFFFFFC0000 :
                        64'hFFFFFFFFFFFFFFFF;
                    bit_ff <= 6'h00;
                    div_ff <= 6'h00;
                end
            end else if (div_ff + 6'h01 >= mgmt_pkg::MDC_HALF) begin
                div_ff <= 6'h00;
                mdc_ff <= !mdc_ff;
                if (mdc_ff) begin
                    // falling edge: present next bit or finish
                    if (bit_ff == mgmt_pkg::XFER_BITS - 6'h01) begin
                        busy_ff <= 1'b0;
                        oe_bit_ff <= 1'b0;
                        mdio_ff <= 1'b1;
                    end else begin
                        bit_ff <= bit_ff + 6'h01;
                        frame_ff <= {frame_ff[62:0], 1'b1};
                        oe_ff <= {oe_ff[62:0], 1'b0};
                        mdio_ff <= frame_ff[62];
                        oe_bit_ff <= oe_ff[62];
                    end
                end else begin
                    if (bit_ff == 6'h00) begin
                        mdio_ff <= frame_ff[63];
                        oe_bit_ff <= oe_ff[63];
                    end
                    if (is_read_ff && bit_ff >= 6'h30) begin
                        rdata_ff <= {rdata_ff[14:0], din_sync_ff[1]};
                    end
                end
            end else begin
                div_ff <= div_ff + 6'h01;
                if (bit_ff == 6'h00 && !mdc_ff) begin
                    mdio_ff <= frame_ff[63];
                    oe_bit_ff <= oe_ff[63];
                end
            end
        end
    end

    assign mgmt.mdc = mdc_ff;
    assign mgmt.sta_mdio_o = mdio_ff;
    assign mgmt.sta_mdio_oe = oe_bit_ff;
endmodule

//--- verif/mgmt_link_properties.sv
// assertions on the shared management link between the two ends
`timescale 1ns/1ps
module mgmt_link_properties (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // management link
    input wire logic mdc,
    input wire logic sta_mdio_o,
    input wire logic sta_mdio_oe,
    input wire logic phy_mdio_o,
    input wire logic phy_mdio_oe,
    input wire logic mdio_line
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    logic mdc_ff;
    logic seen_ff;
    logic [5:0] half_ff;
    logic [6:0] bits_ff;
    logic [7:0] idle_ff;
    logic mdc_rise;
    logic driven;
    assign mdc_rise = mdc && !mdc_ff;
    assign driven = sta_mdio_oe || phy_mdio_oe;
    // length of each mdc level
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            mdc_ff <= 1'b0;
            seen_ff <= 1'b0;
            half_ff <= 6'h00;
        end else begin
            mdc_ff <= mdc;
            if (mdc != mdc_ff) begin
                seen_ff <= 1'b1;
                half_ff <= 6'h01;
            end else if (half_ff != 6'h3F) begin
                half_ff <= half_ff + 6'h01;
            end
        end
    end
    // bit position within a frame, cleared after a long idle
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            idle_ff <= 8'h00;
            bits_ff <= 7'h00;
        end else begin
            if (driven) idle_ff <= 8'h00;
            else if (idle_ff != 8'hFF) idle_ff <= idle_ff + 8'h01;
            if (!driven && idle_ff > 8'h96) bits_ff <= 7'h00;
            else if (mdc_rise)
                bits_ff <= (bits_ff == 7'h3F) ? 7'h00 : bits_ff + 7'h01;
        end
    end
    property p_mdc_rate;
        (mdc != mdc_ff) && seen_ff |-> half_ff >= 6'h19;
    endproperty
    a_mdc_rate: assert property (p_mdc_rate)
        else $error("mdc level shorter than 25 cycles");
    property p_no_contention;
        !(sta_mdio_oe && phy_mdio_oe);
    endproperty
    a_no_contention: assert property (p_no_contention)
        else $error("both ends drive the data line");
    property p_preamble;
        mdc_rise && bits_ff < 7'h20 |-> mdio_line;
    endproperty
    a_preamble: assert property (p_preamble)
        else $error("zero seen within preamble");
    property p_start_zero;
        mdc_rise && bits_ff == 7'h20 |-> !mdio_line;
    endproperty
    a_start_zero: assert property (p_start_zero)
        else $error("start pattern lacks zero");
    property p_start_one;
        mdc_rise && bits_ff == 7'h21 |-> mdio_line;
    endproperty
    a_start_one: assert property (p_start_one)
        else $error("start pattern lacks one");
    property p_ta_float;
        mdc_rise && bits_ff == 7'h2E |-> !phy_mdio_oe && mdio_line;
    endproperty
    a_ta_float: assert property (p_ta_float)
        else $error("first turnaround bit not idle high");
    property p_ta_zero;
        mdc_rise && bits_ff == 7'h2F && driven |-> !mdio_line;
    endproperty
    a_ta_zero: assert property (p_ta_zero)
        else $error("second turnaround bit not zero");
    property p_phy_edge;
        $changed(phy_mdio_o) && phy_mdio_oe |-> !mdc;
    endproperty
    a_phy_edge: assert property (p_phy_edge)
        else $error("read data changed while mdc high");
    property p_phy_first;
        $rose(phy_mdio_oe) |-> !phy_mdio_o ##1 phy_mdio_oe;
    endproperty
    a_phy_first: assert property (p_phy_first)
        else $error("read turnaround not driven low");
    property p_wr_turn;
        mdc_rise && bits_ff == 7'h2E && sta_mdio_oe |-> sta_mdio_o;
    endproperty
    a_wr_turn: assert property (p_wr_turn)
        else $error("write turnaround first bit not one");
endmodule

//--- verif/phy_mgmt_and_pcs_control_tb.sv
// testbench: station and phy ends joined over the management link
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
    err_count++; $display("Error %s exp %h got %h", n, e, g); end end
module phy_mgmt_and_pcs_control_tb;
    logic i_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
    logic [3:0] adr = 4'h0, sel = 4'h0;
    logic [31:0] wdat = 32'h0, rd_wire, rdat;
    logic s_low = 1'b0, s_rep = 1'b1, spd = 1'b1, rxa = 1'b0, txa = 1'b0;
    logic ce = 1'b1;
    logic [4:0] s_addr = 5'h15;
    logic nrzi, bsym, bscr, bnrzi, smode, tser, crs, miic;
    logic [15:0] rv;
    int err_count = 0;
    int tests_run = 0;
    int p;
    always #4 i_clk = ~i_clk;
    mgmt_if mif ();
    sta_mgmt_ctrl sta_mgmt_ctrl_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .i_ce(ce), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
        .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
        .o_wb_dat(rd_wire), .o_wb_ack(ack), .mgmt(mif.sta));
    phy_mgmt_pcs phy_mgmt_pcs_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .i_ce(ce), .mgmt(mif.phy), .i_strap_phy_addr(s_addr),
        .i_strap_byp_symbol(s_low), .i_strap_byp_scramble(s_low),
        .i_strap_byp_all(s_low), .i_strap_repeater(s_rep),
        .i_strap_ten_serial(s_low), .i_speed_100(spd),
        .i_rx_active(rxa), .i_tx_active(txa), .o_nrzi_en(nrzi),
        .o_byp_symbol(bsym), .o_byp_scramble(bscr), .o_byp_nrzi(bnrzi),
        .o_symbol_mode(smode), .o_ten_serial(tser), .o_crs(crs),
        .o_mii_clk(miic));
    mgmt_link_properties mgmt_link_properties_i (.i_clk(i_clk),
        .i_sys_rst(i_sys_rst), .mdc(mif.mdc), .sta_mdio_o(mif.sta_mdio_o),
        .sta_mdio_oe(mif.sta_mdio_oe), .phy_mdio_o(mif.phy_mdio_o),
        .phy_mdio_oe(mif.phy_mdio_oe), .mdio_line(mif.mdio_line));
    task end_sim();
        $display("errors %0d checks %0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge i_clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
        sel <= 4'hF;
        n = 0;
        do begin @(posedge i_clk); n++; end while (ack !== 1'b1 && n < 20);
        if (n >= 20) begin err_count++; end_sim(); end
        rdat = rd_wire;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    // one management frame, then wait for the station to go idle
    task mreg(input logic r, input logic [4:0] ph, input logic [4:0] rg,
              input logic [15:0] d);
        int n;
        if (!r) wb(1'b1, mgmt_pkg::WB_WDATA, {16'h0000, d});
        wb(1'b1, mgmt_pkg::WB_CTRL, {21'h000000, r, ph, rg});
        n = 0;
        do begin
            wb(1'b0, mgmt_pkg::WB_STATUS, 32'h0);
            n++;
        end while (rdat[16] !== 1'b0 && n < 3000);
        if (n >= 3000) begin err_count++; end_sim(); end
        rv = rdat[15:0];
        repeat (8) @(posedge i_clk);
    endtask
    // cycles between two rising edges of the mii clock
    task period(output int q);
        for (int k = 0; k < 2; k++) begin
            q = 0;
            while (miic !== 1'b0 && q < 200) begin @(posedge i_clk); q++; end
            while (miic !== 1'b1 && q < 200) begin @(posedge i_clk); q++; end
        end
        if (q >= 200) begin err_count++; end_sim(); end
    endtask
    initial begin
        repeat (10) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        repeat (2) @(posedge i_clk);
        `CHK("nrzi_en", 1'b1, nrzi)
        mreg(1'b1, 5'h15, 5'h17, 16'h0); `CHK("pcs_cfg", 16'h9000, rv)
        mreg(1'b1, 5'h15, 5'h19, 16'h0); `CHK("phy_addr", 16'h0015, rv)
        mreg(1'b1, 5'h15, 5'h18, 16'h0); `CHK("bypass", 16'h0000, rv)
        txa <= 1'b1;
        repeat (4) @(posedge i_clk); `CHK("crs_tx_rep", 1'b0, crs)
        ce <= 1'b0;
        rxa <= 1'b1;
        repeat (4) @(posedge i_clk); `CHK("ce_hold", 1'b0, crs)
        ce <= 1'b1;
        repeat (4) @(posedge i_clk); `CHK("crs_rx", 1'b1, crs)
        rxa <= 1'b0;
        mreg(1'b0, 5'h15, 5'h17, 16'h8000); `CHK("crs_tx", 1'b1, crs)
        mreg(1'b0, 5'h15, 5'h18, 16'h6000);
        `CHK("byp_symbol", 1'b1, bsym)
        `CHK("byp_scramble", 1'b1, bscr)
        `CHK("symbol_mode", 1'b1, smode)
        mreg(1'b1, 5'h15, 5'h18, 16'h0); `CHK("readback", 16'h6000, rv)
        period(p); `CHK("mii_100", 5, p)
        mreg(1'b0, 5'h15, 5'h18, 16'h1000);
        `CHK("align_nrzi", 1'b1, bnrzi)
        `CHK("align_symbol", 1'b1, bsym)
        `CHK("align_nrzi_en", 1'b0, nrzi)
        mreg(1'b0, 5'h15, 5'h18, 16'h0000);
        mreg(1'b0, 5'h15, 5'h17, 16'h0000);
        `CHK("nrzi_off", 1'b0, nrzi)
        `CHK("nrzi_byp", 1'b1, bnrzi)
        mreg(1'b0, 5'h0A, 5'h17, 16'h1234);
        mreg(1'b1, 5'h15, 5'h17, 16'h0); `CHK("foreign_wr", 16'h0000, rv)
        mreg(1'b1, 5'h0A, 5'h17, 16'h0); `CHK("foreign_rd", 16'hFFFF, rv)
        spd <= 1'b0;
        mreg(1'b0, 5'h15, 5'h18, 16'h6000);
        `CHK("slow_symbol", 1'b0, bsym)
        `CHK("slow_scramble", 1'b0, bscr)
        period(p); `CHK("mii_10", 50, p)
        mreg(1'b0, 5'h15, 5'h1B, 16'h0200); `CHK("serial", 1'b1, tser)
        period(p); `CHK("mii_serial", 13, p)
        wb(1'b0, 4'hC, 32'h0);
        `CHK("unmapped", 32'h00000000, rdat)
        end_sim();
    end
endmodule
